// ===== src/dac_sample_input_latch.sv
`timescale 1ns/1ps
module dac_sample_input_latch #(
  parameter int WIDTH = dac_pkg::SAMPLE_WIDTH,
  parameter int DEPTH = dac_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Sample source.
  input  wire logic [WIDTH-1:0] sample_i,
  input  wire logic             sample_valid_i,
  output      logic             ready_o,
  output      logic             overflow_o,
  // Static straps and power control.
  input  wire logic             format_sel_i,
  input  wire logic             sleep_i,
  output      logic             asleep_o,
  output      logic             powered_down_o,
  // Current array drive.
  output      logic [WIDTH-1:0] true_current_o,
  output      logic [WIDTH-1:0] complement_current_o,
  output      logic             out_valid_o
);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int SC_W  = dac_pkg::SETTLE_COUNT_WIDTH;
  localparam logic [SC_W-1:0] SETTLE_LAST = SC_W'(dac_pkg::SLEEP_SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] READY_LIMIT = CNT_W'(DEPTH - dac_pkg::READY_MARGIN);

  generate
    if (WIDTH != dac_pkg::SAMPLE_WIDTH) begin : g_bad_width
      $error("The current array is built for eight-bit words only.");
    end
    if (DEPTH <= dac_pkg::READY_MARGIN) begin : g_bad_depth
      $error("Buffer depth must exceed the ready margin.");
    end
    if (dac_pkg::MAX_SAMPLE_HZ > dac_pkg::CLOCK_HZ) begin : g_bad_rate
      $error("Sample rate cannot exceed the clock rate.");
    end
    if (dac_pkg::SLEEP_SETTLE_CYCLES > (1 << SC_W)) begin : g_bad_settle
      $error("Settle counter is too narrow for the power-down time.");
    end
  endgenerate

  sample_stream_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) stream ();

  sample_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .bus     (stream.store)
  );

  // Input latch registers.
  logic [WIDTH-1:0] capture_word;
  logic             capture_valid;
  logic             format_q;

  // Power control state.
  dac_pkg::power_state_t power_state;
  dac_pkg::power_state_t next_power_state;
  logic [SC_W-1:0]       settle_count;
  logic [SC_W-1:0]       next_settle_count;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      capture_word  <= '0;
      capture_valid <= 1'b0;
    end else begin
      capture_word  <= sample_i;
      capture_valid <= sample_valid_i && !sleep_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      format_q <= dac_pkg::FORMAT_BINARY;
    end else begin
      format_q <= format_sel_i;
    end
  end

  // The latch feeds the buffer; a word that meets a full buffer is dropped.
  wire accept_word = capture_valid && stream.push_ready;
  wire drop_word   = capture_valid && !stream.push_ready;

  assign stream.push_valid = capture_valid;
  assign stream.push_data  = capture_word;

  // The drain stalls while asleep; sleep also gates the latch, so the buffer holds its words until wake.
  assign stream.pop_ready  = !asleep_o;
  wire drain_word          = stream.pop_valid && stream.pop_ready;

  wire [WIDTH-1:0] msb_mask   = {1'b1, {(WIDTH - 1){1'b0}}};
  wire [WIDTH-1:0] twos_mask  = (format_q == dac_pkg::FORMAT_TWOS) ? msb_mask : '0;
  wire [WIDTH-1:0] array_code = stream.pop_data ^ twos_mask;

  wire [WIDTH-1:0] comp_code;
  generate
    for (genvar b = 0; b < WIDTH; b++) begin : g_pair
      assign comp_code[b] = ~array_code[b];
    end
  endgenerate

  wire room_left = (stream.level < READY_LIMIT);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o    <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      ready_o    <= room_left;
      overflow_o <= drop_word;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i or posedge sleep_i) begin
    if (!rst_n_i) begin
      asleep_o <= 1'b0;
    end else if (sleep_i) begin
      asleep_o <= 1'b1;
    end else begin
      asleep_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      true_current_o       <= dac_pkg::OUT_RESET;
      complement_current_o <= dac_pkg::OUT_RESET;
      out_valid_o          <= 1'b0;
    end else if (asleep_o) begin
      true_current_o       <= dac_pkg::OUT_RESET;
      complement_current_o <= dac_pkg::OUT_RESET;
      out_valid_o          <= 1'b0;
    end else if (drain_word) begin
      true_current_o       <= array_code;
      complement_current_o <= comp_code;
      out_valid_o          <= 1'b1;
    end else begin
      out_valid_o          <= 1'b0;
    end
  end

  always_comb begin
    next_power_state  = power_state;
    next_settle_count = settle_count;
    case (power_state)
      dac_pkg::PWR_ACTIVE: begin
        next_settle_count = '0;
        if (sleep_i) begin
          next_power_state = dac_pkg::PWR_SETTLE;
        end
      end
      dac_pkg::PWR_SETTLE: begin
        if (!sleep_i) begin
          next_power_state  = dac_pkg::PWR_ACTIVE;
          next_settle_count = '0;
        end else if (settle_count == SETTLE_LAST) begin
          next_power_state  = dac_pkg::PWR_DOWN;
        end else begin
          next_settle_count = settle_count + SC_W'(1);
        end
      end
      dac_pkg::PWR_DOWN: begin
        if (!sleep_i) begin
          next_power_state  = dac_pkg::PWR_ACTIVE;
          next_settle_count = '0;
        end
      end
      default: begin
        next_power_state  = dac_pkg::PWR_ACTIVE;
        next_settle_count = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_state    <= dac_pkg::PWR_ACTIVE;
      settle_count   <= '0;
      powered_down_o <= 1'b0;
    end else begin
      power_state    <= next_power_state;
      settle_count   <= next_settle_count;
      powered_down_o <= (next_power_state == dac_pkg::PWR_DOWN);
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  capture_every_edge_a: assert property (
    ##1 capture_word == $past(sample_i))
    else $error("Latch did not take the word present at the edge.");

  msb_order_a: assert property (
    drain_word && !asleep_o && format_q == dac_pkg::FORMAT_BINARY
      |=> true_current_o[dac_pkg::MSB_POS] == $past(stream.pop_data[dac_pkg::MSB_POS])
       && true_current_o[dac_pkg::LSB_POS] == $past(stream.pop_data[dac_pkg::LSB_POS]))
    else $error("Bit order of the array drive is wrong.");

  binary_pass_a: assert property (
    drain_word && format_q == dac_pkg::FORMAT_BINARY
      |=> true_current_o == $past(stream.pop_data))
    else $error("Binary word did not reach the array unchanged.");

  format_default_a: assert property (
    !format_sel_i |=> format_q == dac_pkg::FORMAT_BINARY)
    else $error("Low format strap did not select binary.");

  sleep_async_a: assert property (
    sleep_i |-> asleep_o ##1 (true_current_o == '0 && complement_current_o == '0))
    else $error("Sleep did not quiet the array drive.");

  settle_time_a: assert property (
    $rose(powered_down_o) |-> $past(settle_count) == SETTLE_LAST
      && $past(sleep_i))
    else $error("Power-down flagged before the settle time.");

  complement_pair_a: assert property (
    out_valid_o |-> complement_current_o == ~true_current_o)
    else $error("Complement drive is not the inverse of the true drive.");

  rate_accept_a: assert property (
    ready_o && sample_valid_i && !sleep_i |=> capture_valid ##1 !overflow_o)
    else $error("A word offered with ready high was refused.");

  twos_flip_a: assert property (
    drain_word && format_q == dac_pkg::FORMAT_TWOS
      |=> true_current_o == ($past(stream.pop_data) ^ msb_mask))
    else $error("Twos complement word did not have its top bit flipped.");

  ready_room_a: assert property (
    rst_n_i && stream.level < READY_LIMIT |=> ready_o)
    else $error("Ready stayed low although the buffer had room.");

  ready_margin_a: assert property (
    stream.level >= READY_LIMIT |=> !ready_o)
    else $error("Ready stayed high although the buffer margin was used up.");

  drop_flag_a: assert property (
    overflow_o |-> $past(drop_word))
    else $error("Overflow flagged without a dropped word.");

  accept_path_a: assert property (
    accept_word |=> stream.level != '0)
    else $error("An accepted word did not reach the buffer.");

  asleep_quiet_a: assert property (
    asleep_o |=> !out_valid_o)
    else $error("A word was driven while asleep.");

  latch_gate_a: assert property (
    sleep_i |=> !capture_valid)
    else $error("A word was taken while sleep was high.");

  out_pulse_a: assert property (
    out_valid_o |-> $past(drain_word))
    else $error("Array drive strobed without a buffered word.");

  settle_clear_a: assert property (
    powered_down_o && !sleep_i |=> !powered_down_o)
    else $error("Power-down flag stayed after sleep was released.");

  down_needs_sleep_a: assert property (
    powered_down_o |-> asleep_o)
    else $error("Power-down flagged while the latch was awake.");

  settle_range_a: assert property (
    settle_count <= SETTLE_LAST)
    else $error("Settle counter ran past its last value.");

  power_onehot_a: assert property (
    $onehot(power_state))
    else $error("Power state is not one-hot.");

  twos_min_a: assert property (
    drain_word && format_q == dac_pkg::FORMAT_TWOS && stream.pop_data == msb_mask
      |=> true_current_o == '0)
    else $error("Most negative twos complement word did not give minimum drive.");

  twos_seen_c: cover property (drain_word && format_q == dac_pkg::FORMAT_TWOS);
  full_down_c: cover property ($rose(powered_down_o));
  backpressure_c: cover property ($fell(ready_o) ##[1:20] $rose(ready_o));
  overflow_c: cover property (overflow_o);
  sleep_wake_c: cover property ($fell(asleep_o));
endmodule

// ===== src/dac_pkg.sv
package dac_pkg;

  // Sample word geometry.
  localparam int SAMPLE_WIDTH = 8;
  localparam int MSB_POS      = 7;
  localparam int LSB_POS      = 0;

  // Buffer between the input latch and the current array drivers.
  localparam int FIFO_DEPTH   = 8;
  localparam int READY_MARGIN = 3;

  // Clock rate and the power-down settle time.
  localparam int CLOCK_HZ            = 100_000_000;
  localparam int MAX_SAMPLE_HZ       = 100_000_000;
  localparam int SLEEP_SETTLE_NS     = 5000;
  localparam int SLEEP_SETTLE_CYCLES =
    (SLEEP_SETTLE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_COUNT_WIDTH  = 10;

  // Values after reset and format codes.
  localparam logic [7:0] OUT_RESET     = 8'h00;
  localparam logic       FORMAT_BINARY = 1'b0;
  localparam logic       FORMAT_TWOS   = 1'b1;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SETTLE = 3'b010,
    PWR_DOWN   = 3'b100
  } power_state_t;

endpackage

// ===== src/sample_stream_if.sv
`timescale 1ns/1ps
interface sample_stream_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
);
  logic                       push_valid;
  logic                       push_ready;
  logic [WIDTH-1:0]           push_data;
  logic                       pop_valid;
  logic                       pop_ready;
  logic [WIDTH-1:0]           pop_data;
  logic [$clog2(DEPTH+1)-1:0] level;

  modport store (
    input  push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, level
  );

  modport user (
    output push_valid, push_data, pop_ready,
    input  push_ready, pop_valid, pop_data, level
  );
endinterface

// ===== src/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic     clock_i,
  input  wire logic     rst_n_i,
  // Stream carrier.
  sample_stream_if.store bus
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("sample_fifo needs a power-of-two depth of at least 2.");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;

  wire push_fire = bus.push_valid && bus.push_ready;
  wire pop_fire  = bus.pop_valid && bus.pop_ready;
  wire [CNT_W-1:0] next_count = count + CNT_W'(push_fire) - CNT_W'(pop_fire);

  assign bus.push_ready = (count != CNT_W'(DEPTH));
  assign bus.pop_valid  = (count != '0);
  assign bus.pop_data   = mem[rd_ptr];
  assign bus.level      = count;

  always_ff @(posedge clock_i) begin
    if (push_fire) begin
      mem[wr_ptr] <= bus.push_data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + PTR_W'(push_fire);
      rd_ptr <= rd_ptr + PTR_W'(pop_fire);
      count  <= next_count;
    end
  end

  fifo_bound_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    count <= CNT_W'(DEPTH))
    else $error("FIFO level beyond its depth.");
endmodule

// ===== testbench/sample_source.sv
`timescale 1ns/1ps
module sample_source (
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Bench control.
  input  wire logic       enable_i,
  input  wire logic       format_i,
  input  wire logic       sleep_i,
  // Sample bus.
  input  wire logic       ready_i,
  output      logic [7:0] sample_o,
  output      logic       valid_o
);
  logic [7:0] todo_q[$];
  logic [8:0] sent_q[$];
  integer     seed = 78791;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_o <= 8'h00;
      valid_o  <= 1'b0;
    end else begin
      if (valid_o && !sleep_i) begin
        sent_q.push_back({format_i, sample_o});
      end
      if (todo_q.size() > 0 && ready_i) begin
        sample_o <= todo_q.pop_front();
        valid_o  <= 1'b1;
      end else if (enable_i && ready_i && ($random(seed) % 4 != 0)) begin
        sample_o <= 8'($random(seed));
        valid_o  <= 1'b1;
      end else begin
        // Idle lines show a changing pattern, not the last word.
        sample_o <= ~sample_o;
        valid_o  <= 1'b0;
      end
    end
  end
endmodule

// ===== testbench/dac_sample_input_latch_tb_top.sv
`timescale 1ns/1ps
module dac_sample_input_latch_tb_top;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       enable  = 1'b0;
  logic       fmt     = 1'b0;
  logic       sleep   = 1'b0;
  logic [7:0] sample;
  logic       sample_valid;
  logic       ready;
  logic       overflow;
  logic       asleep;
  logic       powered_down;
  logic [7:0] true_cur;
  logic [7:0] comp_cur;
  logic       out_valid;
  logic [8:0] e;
  int         errors = 0;
  int         total_checks = 0;
  int         seen = 0;

  always #5 clock_i = ~clock_i;

  dac_sample_input_latch DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sample_i(sample), .sample_valid_i(sample_valid),
    .ready_o(ready), .overflow_o(overflow), .format_sel_i(fmt), .sleep_i(sleep),
    .asleep_o(asleep), .powered_down_o(powered_down), .true_current_o(true_cur),
    .complement_current_o(comp_cur), .out_valid_o(out_valid));

  sample_source src (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(enable), .format_i(fmt),
    .sleep_i(sleep), .ready_i(ready), .sample_o(sample), .valid_o(sample_valid));

  function automatic logic [7:0] expect_true(input logic [8:0] w);
    return w[8] ? (w[7:0] ^ 8'h80) : w[7:0];
  endfunction

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d, words out %0d", total_checks, errors, seen);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Scoreboard compares each driven word with what the source handed over.
  always @(negedge clock_i) begin
    if (rst_n_i && overflow !== 1'b0) check(1'b0, "word dropped");
    if (out_valid === 1'b1) begin
      seen++;
      if (src.sent_q.size() == 0) begin
        check(1'b0, "word out of nowhere");
      end else begin
        e = src.sent_q.pop_front();
        check(true_cur === expect_true(e), "true drive code");
        check(comp_cur === ~expect_true(e), "complement code");
      end
    end
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clock_i);
    check(true_cur === 8'h00 && out_valid === 1'b0, "reset outputs");
    rst_n_i <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      @(posedge clock_i);
      fmt <= f[0];
      @(posedge clock_i);
      src.todo_q = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h01, 8'hFE};
      repeat (14) @(posedge clock_i);
      check(src.sent_q.size() == 0, "corner words pending");
      enable <= 1'b1;
      repeat (150) @(posedge clock_i);
      enable <= 1'b0;
      repeat (12) @(posedge clock_i);
      check(src.sent_q.size() == 0, "random words pending");
      $display("format %0d stream done", f);
    end
    @(posedge clock_i);
    sleep <= 1'b1;
    src.todo_q = '{8'h55, 8'hAA};
    #1;
    check(asleep === 1'b1, "sleep not immediate");
    @(posedge clock_i);
    #1;
    check(true_cur === 8'h00 && comp_cur === 8'h00, "drive while asleep");
    repeat (dac_pkg::SLEEP_SETTLE_CYCLES - 3) @(posedge clock_i);
    #1;
    check(powered_down === 1'b0, "powered down early");
    repeat (4) @(posedge clock_i);
    #1;
    check(powered_down === 1'b1, "not powered down");
    src.todo_q.delete();
    @(posedge clock_i);
    sleep <= 1'b0;
    @(posedge clock_i);
    #1;
    check(asleep === 1'b0 && powered_down === 1'b0, "no wake");
    check(ready === 1'b1 && overflow === 1'b0, "not ready after wake");
    repeat (12) @(posedge clock_i);
    check(src.sent_q.size() == 0 && seen > 12, "words lost");
    $display("sleep test done");
    report_and_stop();
  end
endmodule
